// ---- dma_pkg.sv ----
// shared constants for the peripheral dma channel pair
package dma_pkg;

    // ---------------------------------------------------------------
    // register offsets inside the owning peripheral's space
    // ---------------------------------------------------------------
    localparam int           ADDR_W        = 12;
    localparam logic [11:0]  RX_PTR_OFF    = 12'h100;
    localparam logic [11:0]  RX_CNT_OFF    = 12'h104;
    localparam logic [11:0]  TX_PTR_OFF    = 12'h108;
    localparam logic [11:0]  TX_CNT_OFF    = 12'h10C;
    localparam logic [11:0]  RX_NPTR_OFF   = 12'h110;
    localparam logic [11:0]  RX_NCNT_OFF   = 12'h114;
    localparam logic [11:0]  TX_NPTR_OFF   = 12'h118;
    localparam logic [11:0]  TX_NCNT_OFF   = 12'h11C;
    localparam logic [11:0]  CTRL_OFF      = 12'h120;
    localparam logic [11:0]  STAT_OFF      = 12'h124;

    // ---------------------------------------------------------------
    // field positions; channel 0 is receive, channel 1 is transmit
    // ---------------------------------------------------------------
    localparam int           CH_ON_BIT [2] = '{0, 8};
    localparam int           CH_OFF_BIT[2] = '{1, 9};
    localparam int           CH_EN_BIT [2] = '{0, 8};
    localparam int           CH_END_BIT[2] = '{16, 18};
    localparam int           CH_ALL_BIT[2] = '{17, 19};

    // ---------------------------------------------------------------
    // reset values and transfer sizes
    // ---------------------------------------------------------------
    localparam logic [31:0]  PTR_RST       = 32'h0000_0000;
    localparam logic [15:0]  CNT_RST       = 16'h0000;
    localparam logic [1:0]   SIZE_BYTE     = 2'h0;
    localparam logic [1:0]   SIZE_HALF     = 2'h1;
    localparam logic [1:0]   SIZE_WORD     = 2'h2;
    localparam logic [31:0]  STEP_BYTE     = 32'h0000_0001;
    localparam logic [31:0]  STEP_HALF     = 32'h0000_0002;
    localparam logic [31:0]  STEP_WORD     = 32'h0000_0004;

    // ---------------------------------------------------------------
    // transfer sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE      = 7'b0000001,
        ST_GRANT     = 7'b0000010,
        ST_RX_PERIPH = 7'b0000100,
        ST_RX_MEM    = 7'b0001000,
        ST_TX_MEM    = 7'b0010000,
        ST_TX_PERIPH = 7'b0100000,
        ST_UPDATE    = 7'b1000000
    } xfer_state_t;

endpackage

// ---- peripheral_dma.sv ----
// receive and transmit dma channel pair with apb registers and memory master
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// How it works
// RL1 - one receive and one transmit channel
// RL2 - registers start at offset 0x100
// RL3 - four 32-bit pointers, four 16-bit counters
// RL4 - current count reads remaining transfers anytime
// RL5 - current pointer reads present transfer address
// RL6 - write-only control: separate on/off per channel
// RL7 - status shows each channel enabled
// RL8 - end flags go out to peripheral
// RL9 - receive done when receive count hits zero
// RL10 - receive all full when both counts zero
// RL11 - transmit done when transmit count hits zero
// RL12 - transmit all empty when both counts zero
// RL13 - pointer advances by 1, 2 or 4
// RL14 - pointer rewrite while active takes effect
// RL15 - counter decrements once per transfer
// RL16 - counter zero stops channel unless chained
// RL17 - both counts zero ignores requests, flags end
// RL18 - peripheral requests by ready signals
// RL19 - peripheral raises its own end interrupt
// RL20 - pointer may address whole memory space
// RL21 - chain loads next pointer and count
// RL22 - next count cleared after loading
// RL23 - counter write clears channel end flags
// RL24 - arrival order, receive first when simultaneous
// RL25 - rx: peripheral then memory; tx: reverse
// RL26 - disable beats enable in one write
module peripheral_dma
    import dma_pkg::*;
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // peripheral side
    input  wire logic               rx_request,
    input  wire logic               tx_request,
    input  wire logic [1:0]         xfer_size,
    input  wire logic [31:0]        rx_holding_word,
    output logic                    rx_take,
    output logic                    tx_write,
    output logic      [31:0]        tx_data,
    output logic                    rx_buffer_done,
    output logic                    rx_all_buffers_full,
    output logic                    tx_buffer_done,
    output logic                    tx_all_buffers_empty,
    // system bus master
    output logic                    mem_req,
    input  wire logic               mem_gnt,
    output logic                    mem_valid,
    output logic                    mem_write,
    output logic      [31:0]        mem_addr,
    output logic      [1:0]         mem_size,
    output logic      [31:0]        mem_wdata,
    input  wire logic               mem_ready,
    input  wire logic [31:0]        mem_rdata
);

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic              wr_en;
    logic [11:0]       off;
    logic [31:0]       rdata_d;
    logic              err_d;
    logic [31:0]       prdata_q;
    logic              pslverr_q;

    logic [31:0]       cur_ptr_q  [2];                           // RL3
    logic [31:0]       nxt_ptr_q  [2];
    logic [15:0]       cur_cnt_q  [2];
    logic [15:0]       nxt_cnt_q  [2];
    logic              en_q       [2];
    logic              end_q      [2];
    logic              all_q      [2];
    logic              xfer_done  [2];

    assign off   = 12'(paddr);
    assign wr_en = psel & penable & pwrite;

    assign pready  = psel & penable;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // read data is captured in the setup cycle so the access phase needs no wait
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        unique case (off)
            RX_PTR_OFF:  rdata_d = cur_ptr_q[0];                 // RL5
            TX_PTR_OFF:  rdata_d = cur_ptr_q[1];                 // RL5
            RX_CNT_OFF:  rdata_d = {16'h0000, cur_cnt_q[0]};     // RL4
            TX_CNT_OFF:  rdata_d = {16'h0000, cur_cnt_q[1]};     // RL4
            RX_NPTR_OFF: rdata_d = nxt_ptr_q[0];
            TX_NPTR_OFF: rdata_d = nxt_ptr_q[1];
            RX_NCNT_OFF: rdata_d = {16'h0000, nxt_cnt_q[0]};
            TX_NCNT_OFF: rdata_d = {16'h0000, nxt_cnt_q[1]};
            CTRL_OFF:    rdata_d = 32'h0000_0000;                // RL6
            STAT_OFF: begin
                rdata_d[CH_EN_BIT[0]]  = en_q[0];                // RL7
                rdata_d[CH_EN_BIT[1]]  = en_q[1];                // RL7
                rdata_d[CH_END_BIT[0]] = end_q[0];
                rdata_d[CH_END_BIT[1]] = end_q[1];
                rdata_d[CH_ALL_BIT[0]] = all_q[0];
                rdata_d[CH_ALL_BIT[1]] = all_q[1];
            end
            default:     err_d   = 1'b1;                         // RL2
        endcase

        // control and status are one-way registers
        if (pwrite && off == STAT_OFF) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= err_d;
        end
    end

    // ---------------------------------------------------------------
    // transfer sequencer
    // ---------------------------------------------------------------
    xfer_state_t       state_q, state_d;
    logic              sel_q, sel_d;
    logic [31:0]       data_q, data_d;
    logic              tx_older_q, tx_older_d;
    logic              pend [2];
    logic [31:0]       step;

    always_comb begin
        unique case (xfer_size)
            SIZE_BYTE: step = STEP_BYTE;                         // RL13
            SIZE_HALF: step = STEP_HALF;                         // RL13
            default:   step = STEP_WORD;                         // RL13
        endcase
    end

    // a channel with no count left ignores its peripheral entirely
    assign pend[0] = rx_request & en_q[0] & (cur_cnt_q[0] != CNT_RST);  // RL18 RL16 RL17
    assign pend[1] = tx_request & en_q[1] & (cur_cnt_q[1] != CNT_RST);  // RL18 RL16 RL17

    always_comb begin
        state_d    = state_q;
        sel_d      = sel_q;
        data_d     = data_q;
        tx_older_d = tx_older_q;

        // remember that transmit was waiting before receive arrived
        if (pend[1] && !pend[0]) begin
            tx_older_d = 1'b1;                                   // RL24
        end else if (!pend[1]) begin
            tx_older_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (pend[0] || pend[1]) begin
                    sel_d   = pend[1] & (!pend[0] | tx_older_q); // RL24
                    state_d = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (mem_gnt) begin
                    state_d = sel_q ? ST_TX_MEM : ST_RX_PERIPH;  // RL25
                end
            end
            ST_RX_PERIPH: begin
                data_d  = rx_holding_word;                       // RL25
                state_d = ST_RX_MEM;
            end
            ST_RX_MEM: begin
                if (mem_ready) begin
                    state_d = ST_UPDATE;
                end
            end
            ST_TX_MEM: begin
                if (mem_ready) begin
                    data_d  = mem_rdata;                         // RL25
                    state_d = ST_TX_PERIPH;
                end
            end
            ST_TX_PERIPH: begin
                state_d    = ST_UPDATE;
                tx_older_d = 1'b0;
            end
            ST_UPDATE: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            sel_q      <= 1'b0;
            data_q     <= 32'h0000_0000;
            tx_older_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            sel_q      <= sel_d;
            data_q     <= data_d;
            tx_older_q <= tx_older_d;
        end
    end

    assign mem_req   = (state_q != ST_IDLE) & (state_q != ST_UPDATE);
    assign mem_valid = (state_q == ST_RX_MEM) | (state_q == ST_TX_MEM);
    assign mem_write = (state_q == ST_RX_MEM);

    assign mem_addr  = cur_ptr_q[sel_q];                         // RL20
    assign mem_size  = xfer_size;
    assign mem_wdata = data_q;

    assign rx_take   = (state_q == ST_RX_PERIPH);
    assign tx_write  = (state_q == ST_TX_PERIPH);
    assign tx_data   = data_q;

    assign xfer_done[0] = (state_q == ST_UPDATE) & !sel_q;
    assign xfer_done[1] = (state_q == ST_UPDATE) & sel_q;

    assign rx_buffer_done       = end_q[0];                      // RL8
    assign rx_all_buffers_full  = all_q[0];                      // RL8
    assign tx_buffer_done       = end_q[1];                      // RL8
    assign tx_all_buffers_empty = all_q[1];                      // RL8

    // ---------------------------------------------------------------
    // per-channel pointers, counters, enables and end flags
    // ---------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch                  // RL1
        logic [11:0] ptr_off;
        logic [11:0] cnt_off;
        logic [11:0] nptr_off;
        logic [11:0] ncnt_off;
        logic [31:0] cur_ptr_d;
        logic [31:0] nxt_ptr_d;
        logic [15:0] cur_cnt_d;
        logic [15:0] nxt_cnt_d;
        logic        en_d;
        logic        end_d;
        logic        all_d;
        logic        cnt_wr;
        logic        hit_zero;
        logic        hit_all;
        logic        chained;

        assign ptr_off  = (c == 0) ? RX_PTR_OFF  : TX_PTR_OFF;   // RL2
        assign cnt_off  = (c == 0) ? RX_CNT_OFF  : TX_CNT_OFF;
        assign nptr_off = (c == 0) ? RX_NPTR_OFF : TX_NPTR_OFF;
        assign ncnt_off = (c == 0) ? RX_NCNT_OFF : TX_NCNT_OFF;

        always_comb begin
            cur_ptr_d = cur_ptr_q[c];
            nxt_ptr_d = nxt_ptr_q[c];
            cur_cnt_d = cur_cnt_q[c];
            nxt_cnt_d = nxt_cnt_q[c];
            en_d      = en_q[c];
            cnt_wr    = 1'b0;
            chained   = 1'b0;

            // a finished transfer moves the channel on
            if (xfer_done[c]) begin
                cur_ptr_d = cur_ptr_q[c] + step;                 // RL13
                cur_cnt_d = cur_cnt_q[c] - 16'h0001;             // RL15
                if (cur_cnt_d == CNT_RST && nxt_cnt_q[c] != CNT_RST) begin
                    cur_ptr_d = nxt_ptr_q[c];                    // RL21
                    cur_cnt_d = nxt_cnt_q[c];                    // RL21
                    nxt_cnt_d = CNT_RST;                         // RL22
                    // the drained buffer still counts as ended
                    chained   = 1'b1;                            // RL9 RL11
                end
            end

            // software writes land after the update, so a new pointer wins
            if (wr_en) begin
                if (off == ptr_off) begin
                    cur_ptr_d = pwdata;                          // RL14
                end
                if (off == nptr_off) begin
                    nxt_ptr_d = pwdata;
                end
                if (off == cnt_off) begin
                    cur_cnt_d = pwdata[15:0];
                    cnt_wr    = 1'b1;
                end
                if (off == ncnt_off) begin
                    nxt_cnt_d = pwdata[15:0];
                    cnt_wr    = 1'b1;
                end
                if (off == CTRL_OFF) begin
                    if (pwdata[CH_OFF_BIT[c]]) begin
                        en_d = 1'b0;                             // RL26 RL6
                    end else if (pwdata[CH_ON_BIT[c]]) begin
                        en_d = 1'b1;                             // RL6
                    end
                end
            end

            // flags fire on the step into zero; the set beats a clearing write
            hit_zero = ((cur_cnt_d == CNT_RST) & (cur_cnt_q[c] != CNT_RST)) | chained;  // RL9 RL11
            hit_all  = (cur_cnt_d == CNT_RST) & (nxt_cnt_d == CNT_RST)
                     & ~((cur_cnt_q[c] == CNT_RST) & (nxt_cnt_q[c] == CNT_RST));  // RL10 RL12
            end_d = hit_zero | (end_q[c] & ~cnt_wr);             // RL23 RL17
            all_d = hit_all | (all_q[c] & ~cnt_wr);              // RL23
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cur_ptr_q[c] <= PTR_RST;
                nxt_ptr_q[c] <= PTR_RST;
                cur_cnt_q[c] <= CNT_RST;
                nxt_cnt_q[c] <= CNT_RST;
                en_q[c]      <= 1'b0;
                end_q[c]     <= 1'b0;
                all_q[c]     <= 1'b0;
            end else begin
                cur_ptr_q[c] <= cur_ptr_d;
                nxt_ptr_q[c] <= nxt_ptr_d;
                cur_cnt_q[c] <= cur_cnt_d;
                nxt_cnt_q[c] <= nxt_cnt_d;
                en_q[c]      <= en_d;
                end_q[c]     <= end_d;
                all_q[c]     <= all_d;
            end
        end
    end

endmodule

// ---- peripheral_dma_sva.sv ----
// concurrent checks on the dma channel pair ports
`timescale 1ns/1ps
module peripheral_dma_sva
    import dma_pkg::*;
(
    input wire logic              pclk, presetn, psel, penable, pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata, mem_addr, pwdata,
    input wire logic              pready, pslverr, rx_take, tx_write,
    input wire logic              rx_buffer_done, rx_all_buffers_full,
    input wire logic              mem_req, mem_gnt, mem_valid, mem_write, mem_ready,
    input wire logic [1:0]        xfer_size, mem_size
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (pready == (psel && penable)) else $error("pready off access phase");
    a_rx_after_grant: assert property (rx_take |-> $past(mem_req) && $past(mem_gnt))
        else $error("rx before grant");
    a_rx_then_mem: assert property (rx_take |=> mem_valid && mem_write) else $error("rx not to memory");
    a_tx_after_read: assert property (tx_write |-> $past(mem_valid) && $past(mem_ready) && !$past(mem_write))
        else $error("tx before memory read");
    a_take_pulse: assert property (rx_take |=> !rx_take) else $error("rx take too long");
    a_write_pulse: assert property (tx_write |=> !tx_write) else $error("tx write too long");
    a_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_write))
        else $error("memory request dropped");
    a_size_passed: assert property (mem_valid |-> mem_req && mem_size == xfer_size)
        else $error("memory size wrong");
    a_stat_ro: assert property (psel && !penable && pwrite && paddr == STAT_OFF |=> pslverr)
        else $error("status write accepted");
    a_unmapped: assert property (psel && !penable && paddr < RX_PTR_OFF |=> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");
    a_end_clear: assert property (psel && penable && pwrite && paddr == RX_NCNT_OFF
        && !($past(mem_valid) && $past(mem_ready)) |=> !rx_buffer_done
        && (!rx_all_buffers_full || $past(pwdata) == 32'h0)) else $error("rx flags not cleared");
endmodule
bind peripheral_dma peripheral_dma_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .mem_addr(mem_addr), .pready(pready), .pslverr(pslverr),
    .rx_take(rx_take), .tx_write(tx_write), .rx_buffer_done(rx_buffer_done), .pwdata(pwdata),
    .rx_all_buffers_full(rx_all_buffers_full), .mem_req(mem_req), .mem_gnt(mem_gnt), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_ready(mem_ready), .xfer_size(xfer_size), .mem_size(mem_size));

// ---- pdma_far_model.sv ----
// serial peripheral request source and system memory model
`timescale 1ns/1ps
module pdma_far_model (
    // clock, reset and test controls
    input  wire logic        pclk, presetn, rx_want, tx_want,
    input  wire logic [1:0]  lat,
    // peripheral side
    input  wire logic        rx_take, tx_write, rx_done, tx_done,
    output logic             rx_request, tx_request, end_irq,
    output logic [31:0]      rx_holding_word,
    // memory side
    input  wire logic        mem_req, mem_valid, mem_write,
    input  wire logic [31:0] mem_addr, mem_wdata,
    output logic             mem_gnt, mem_ready,
    output logic [31:0]      mem_rdata
);
    logic [1:0]  wait_q;
    logic [15:0] seq_q;
    logic [7:0]  n_acc;
    logic [31:0] log_a [8];
    logic [31:0] log_d [8];
    logic        log_w [8];
    assign rx_holding_word = {16'hC0DE, seq_q};
    assign mem_gnt   = mem_req && (wait_q == lat);
    assign mem_ready = mem_valid && (wait_q == lat);
    assign end_irq   = rx_done | tx_done;
    // outside the answer cycle the read bus shows the inverse pattern
    assign mem_rdata = mem_ready ? (mem_addr ^ 32'h5A5A_0000) : ~(mem_addr ^ 32'h5A5A_0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_request <= 1'b0;
            tx_request <= 1'b0;
            wait_q     <= 2'h0;
            seq_q      <= 16'h0000;
            n_acc      <= 8'h00;
        end else begin
            rx_request <= rx_take ? 1'b0 : rx_want;
            tx_request <= tx_write ? 1'b0 : tx_want;
            if (rx_take)
                seq_q <= seq_q + 16'h0001;
            if (mem_valid)
                wait_q <= mem_ready ? 2'h0 : wait_q + 2'h1;
            else
                wait_q <= (mem_req && !mem_gnt) ? wait_q + 2'h1 : 2'h0;
            if (mem_ready) begin
                log_a[n_acc[2:0]] <= mem_addr;
                log_w[n_acc[2:0]] <= mem_write;
                log_d[n_acc[2:0]] <= mem_write ? mem_wdata : mem_rdata;
                n_acc             <= n_acc + 8'h01;
            end
        end
    end
endmodule

// ---- peripheral_dma_tb.sv ----
// register-level testbench for the dma channel pair
`timescale 1ns/1ps
module peripheral_dma_tb;
    import dma_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_want = 0, tx_want = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, tx_data, mem_addr, mem_wdata, mem_rdata, rx_holding_word;
    logic [1:0]  xfer_size = 2'h0, lat = 2'h0, mem_size;
    logic pready, pslverr, rx_request, tx_request, rx_take, tx_write, mem_req, mem_gnt, mem_valid, end_irq;
    logic mem_write, mem_ready, rx_buffer_done, rx_all_buffers_full, tx_buffer_done, tx_all_buffers_empty;
    int n_errors = 0, samples_checked = 0;
    localparam logic [11:0] REGS [10] = '{RX_PTR_OFF, RX_CNT_OFF, TX_PTR_OFF, TX_CNT_OFF, RX_NPTR_OFF,
                                          RX_NCNT_OFF, TX_NPTR_OFF, TX_NCNT_OFF, CTRL_OFF, STAT_OFF};
    localparam logic [31:0] STEPS [3] = '{STEP_BYTE, STEP_HALF, STEP_WORD};
    localparam logic [1:0]  SIZES [3] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD};
    localparam logic [31:0] RX_ADDR [3] = '{32'hF000_0000, 32'hF000_0001, 32'h0000_4000};
    always #10 pclk = ~pclk;
    peripheral_dma dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_request(rx_request), .tx_request(tx_request), .xfer_size(xfer_size),
        .rx_holding_word(rx_holding_word), .rx_take(rx_take), .tx_write(tx_write), .tx_data(tx_data),
        .rx_buffer_done(rx_buffer_done), .rx_all_buffers_full(rx_all_buffers_full),
        .tx_buffer_done(tx_buffer_done), .tx_all_buffers_empty(tx_all_buffers_empty), .mem_req(mem_req),
        .mem_gnt(mem_gnt), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    pdma_far_model m (.pclk(pclk), .presetn(presetn), .rx_want(rx_want), .tx_want(tx_want), .lat(lat),
        .rx_take(rx_take), .tx_write(tx_write), .rx_request(rx_request), .tx_request(tx_request),
        .rx_holding_word(rx_holding_word), .mem_req(mem_req), .mem_valid(mem_valid), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .rx_done(rx_buffer_done), .tx_done(tx_buffer_done), .end_irq(end_irq));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", n, exp, got);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 50) begin
            n_errors++;
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, exp, r);
    endtask
    task automatic wait_acc(input logic [7:0] target);
        int i;
        for (i = 0; i < 400 && m.n_acc !== target; i++)
            @(posedge pclk);
        if (i == 400) begin
            n_errors++;
            finish_test();
        end
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (REGS[i]) rd_chk("reset value", REGS[i], 32'h0);
        apb(1'b0, 12'h0FC, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, STAT_OFF, 32'hFFFF_FFFF, r, e);
        chk("status write error", 32'h1, {31'h0, e});
        $display("test registers done");
        wr(RX_CNT_OFF, 32'hFFFF_0002);
        rd_chk("rx count", RX_CNT_OFF, 32'h0000_0002);
        wr(RX_PTR_OFF, RX_ADDR[0]);
        wr(RX_NPTR_OFF, RX_ADDR[2]);
        wr(RX_NCNT_OFF, 32'h1);
        wr(CTRL_OFF, 32'h3);
        rd_chk("off beats on", STAT_OFF, 32'h0);
        rx_want <= 1'b1;
        repeat (20) @(posedge pclk);
        rd_chk("frozen count", RX_CNT_OFF, 32'h2);
        wr(CTRL_OFF, 32'h1);
        wait_acc(8'd3);
        repeat (20) @(posedge pclk);
        chk("rx transfers", 32'd3, {24'h0, m.n_acc});
        rd_chk("rx count end", RX_CNT_OFF, 32'h0);
        rd_chk("rx next count", RX_NCNT_OFF, 32'h0);
        rd_chk("rx pointer", RX_PTR_OFF, 32'h0000_4001);
        rd_chk("rx status", STAT_OFF, 32'h0003_0001);
        chk("rx flag pins", 32'h3, {30'h0, rx_all_buffers_full, rx_buffer_done});
        chk("end interrupt", 32'h1, {31'h0, end_irq});
        for (int k = 0; k < 3; k++) begin
            chk("rx address", RX_ADDR[k], m.log_a[k]);
            chk("rx direction", 32'h1, {31'h0, m.log_w[k]});
            chk("rx data", 32'(k), m.log_d[k] & 32'hFF);
        end
        rx_want <= 1'b0;
        wr(CTRL_OFF, 32'h2);
        rd_chk("rx off", STAT_OFF, 32'h0003_0000);
        wr(RX_NCNT_OFF, 32'h0);
        rd_chk("rx flags cleared", STAT_OFF, 32'h0);
        chk("end interrupt off", 32'h0, {31'h0, end_irq});
        $display("test receive chain done");
        lat <= 2'h3;
        wr(CTRL_OFF, 32'h100);
        for (int s = 0; s < 3; s++) begin
            xfer_size <= SIZES[s];
            wr(TX_PTR_OFF, 32'h100);
            wr(TX_CNT_OFF, 32'h1);
            rd_chk("tx flags cleared", STAT_OFF, 32'h100);
            tx_want <= 1'b1;
            wait_acc(8'(4 + s));
            tx_want <= 1'b0;
            rd_chk("tx pointer", TX_PTR_OFF, 32'h100 + STEPS[s]);
            chk("tx direction", 32'h0, {31'h0, m.log_w[3 + s]});
            chk("tx data", 32'h5A5A_0100, tx_data);
            rd_chk("tx status", STAT_OFF, 32'h000C_0100);
            chk("tx flag pins", 32'h3, {30'h0, tx_all_buffers_empty, tx_buffer_done});
        end
        $display("test transmit sizes done");
        lat <= 2'h0;
        xfer_size <= SIZE_WORD;
        wr(RX_CNT_OFF, 32'h1);
        wr(TX_CNT_OFF, 32'h1);
        wr(CTRL_OFF, 32'h101);
        rx_want <= 1'b1;
        tx_want <= 1'b1;
        wait_acc(8'd8);
        rx_want <= 1'b0;
        tx_want <= 1'b0;
        chk("first served rx", 32'h1, {31'h0, m.log_w[6]});
        chk("second served tx", 32'h0, {31'h0, m.log_w[7]});
        $display("test arbitration done");
        finish_test();
    end
endmodule
